// ### verilog/timer01_defines.svh
// Register addresses, bit positions, reset values and divider counts for timers 0 and 1
`ifndef TIMER01_DEFINES_SVH
`define TIMER01_DEFINES_SVH

// -----------------------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------------------
`define ADDR_TIMER_CONTROL_STATUS 8'h88
`define ADDR_TIMER_MODE_SELECT    8'h89
`define ADDR_TIMER0_LOW_BYTE      8'h8a
`define ADDR_TIMER1_LOW_BYTE      8'h8b
`define ADDR_TIMER0_HIGH_BYTE     8'h8c
`define ADDR_TIMER1_HIGH_BYTE     8'h8d
`define ADDR_TIMER_CLOCK_SELECT   8'h8e

// -----------------------------------------------------------------------------
// Control/status bit positions
// -----------------------------------------------------------------------------
`define BIT_TIMER1_OVERFLOW_FLAG  7
`define BIT_TIMER1_RUN            6
`define BIT_TIMER0_OVERFLOW_FLAG  5
`define BIT_TIMER0_RUN            4
`define BIT_EXT_IRQ1_FLAG         3
`define BIT_EXT_IRQ1_TRIGGER_TYPE 2
`define BIT_EXT_IRQ0_FLAG         1
`define BIT_EXT_IRQ0_TRIGGER_TYPE 0

// -----------------------------------------------------------------------------
// Mode select bit positions
// -----------------------------------------------------------------------------
`define BIT_TIMER1_GATE_ENABLE    7
`define BIT_TIMER1_COUNT_SELECT   6
`define POS_TIMER1_MODE_FIELD     4
`define BIT_TIMER0_GATE_ENABLE    3
`define BIT_TIMER0_COUNT_SELECT   2
`define POS_TIMER0_MODE_FIELD     0

// -----------------------------------------------------------------------------
// Clock select bit positions
// -----------------------------------------------------------------------------
`define BIT_TIMER3_HIGH_CLOCK     7
`define BIT_TIMER3_LOW_CLOCK      6
`define BIT_TIMER2_HIGH_CLOCK     5
`define BIT_TIMER2_LOW_CLOCK      4
`define BIT_TIMER1_CLOCK_CHOICE   3
`define BIT_TIMER0_CLOCK_CHOICE   2
`define POS_PRESCALE_SELECT       0

// -----------------------------------------------------------------------------
// Reset values and prescaler divisors
// -----------------------------------------------------------------------------
`define RESET_CONTROL_STATUS      8'h00
`define RESET_MODE_SELECT         8'h00
`define RESET_CLOCK_SELECT        8'h00
`define RESET_COUNT_BYTE          8'h00
`define PRESC_DIV12               12
`define PRESC_DIV4                4
`define PRESC_DIV48               48

`endif

// ### verilog/timer01_pkg.sv
// Types shared by the timer 0/1 block
package timer01_pkg;

   // Two-bit mode field encodings
   typedef enum logic [1:0] {
      MODE_13BIT  = 2'h0,
      MODE_16BIT  = 2'h1,
      MODE_8RELOAD = 2'h2,
      MODE_SPLIT  = 2'h3
   } timer_mode_t;

   // Prescale field encodings
   typedef enum logic [1:0] {
      PRE_DIV12  = 2'h0,
      PRE_DIV4   = 2'h1,
      PRE_DIV48  = 2'h2,
      PRE_EXT8   = 2'h3
   } prescale_t;

   // Special function register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;

   // Result of one count step
   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic       ovf;
   } count_step_t;

   // Vectoring acknowledges from the core
   typedef struct packed {
      logic timer0;
      logic timer1;
      logic ext_irq0;
      logic ext_irq1;
   } vector_ack_t;

endpackage

// ### verilog/timer01_split_mode_and_control.sv
// Timers 0 and 1 with split mode, control/status, mode and clock-select registers
`timescale 1ns/1ns
`default_nettype none
`include "timer01_defines.svh"

// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------

module timer01_split_mode_and_control
   import timer01_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire sfr_req_t    sfr_req,
   output logic [7:0]       sfr_rdata,
   input  wire vector_ack_t vector_ack,
   input  wire logic        ext_irq0_input,
   input  wire logic        ext_irq1_input,
   input  wire logic        ext_irq0_polarity,
   input  wire logic        ext_irq1_polarity,
   input  wire logic        timer0_event_pin,
   input  wire logic        timer1_event_pin,
   input  wire logic        ext_clk_div8,
   input  wire logic        timer2_alt_clock_choice,
   input  wire logic        timer3_alt_clock_choice,
   input  wire logic        timer2_split,
   input  wire logic        timer3_split,
   output logic             timer0_irq_req,
   output logic             timer1_irq_req,
   output logic             ext_irq0_req,
   output logic             ext_irq1_req,
   output logic             timer1_overflow_pulse,
   output logic             timer2_low_tick,
   output logic             timer2_high_tick,
   output logic             timer3_low_tick,
   output logic             timer3_high_tick
);

   // Synchroniser must have at least two flops
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
   end

   localparam int NPIN = 5;
   localparam int PRE_DIV [0:2] = '{`PRESC_DIV12, `PRESC_DIV4, `PRESC_DIV48};

   // -----------------------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------------------

   // Write strobe for one register address
   function automatic logic wr_hit(input sfr_req_t req, input logic [7:0] addr);
      wr_hit = req.wr && (req.addr == addr);
   endfunction

   // One count step of a timer in the given mode
   function automatic count_step_t count_step(input logic [1:0] mode,
                                              input logic [7:0] lo,
                                              input logic [7:0] hi);
      count_step_t s;
      logic [12:0] c13;
      s.lo  = lo;
      s.hi  = hi;
      s.ovf = 1'b0;
      c13   = {hi, lo[4:0]};
      case (mode)
         MODE_13BIT: begin
            s.ovf = &c13;
            c13   = c13 + 13'h1;
            s.hi  = c13[12:5];
            s.lo  = {lo[7:5], c13[4:0]};                   // Upper three bits left alone
         end
         MODE_16BIT: begin
            s.ovf        = &{hi, lo};
            {s.hi, s.lo} = {hi, lo} + 16'h1;
         end
         MODE_8RELOAD: begin
            s.ovf = &lo;
            s.lo  = (&lo) ? hi : lo + 8'h1;
         end
         default: begin
            s.ovf = &lo;
            s.lo  = lo + 8'h1;
         end
      endcase
      count_step = s;
   endfunction

   // -----------------------------------------------------------------------------
   // Registers and pin synchronisers
   // -----------------------------------------------------------------------------
   logic [7:0]      timer_control_status_r;
   logic [7:0]      timer_mode_select_r;
   logic [7:0]      timer_clock_select_r;
   logic [7:0]      tl0_r;
   logic [7:0]      th0_r;
   logic [7:0]      tl1_r;
   logic [7:0]      th1_r;
   logic [NPIN-1:0] sync_r [SYNC_STAGES];
   logic [NPIN-1:0] pin_prev_r;
   logic [1:0]      irq_act_prev_r;
   logic [5:0]      pre_cnt_r [3];
   logic [2:0]      pre_tick;

   // Pin vector: irq0, irq1, event0, event1, ext div 8
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   assign pin_raw = {ext_clk_div8, timer1_event_pin, timer0_event_pin,
                     ext_irq1_input, ext_irq0_input};
   assign pin_s   = sync_r[SYNC_STAGES-1];

   // Pins are asynchronous: two flops before any logic looks at them
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_r[i] <= '0;
         end
         pin_prev_r <= '0;
      end else if (clk_en) begin
         sync_r[0] <= pin_raw;
         for (int i = 1; i < SYNC_STAGES; i++) begin
            sync_r[i] <= sync_r[i-1];
         end
         pin_prev_r <= pin_s;
      end
   end

   // -----------------------------------------------------------------------------
   // Prescaler: free-running dividers, one per system divisor
   // -----------------------------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_pre
      assign pre_tick[g] = (pre_cnt_r[g] == 6'(PRE_DIV[g] - 1));
      always_ff @(posedge core_clk or negedge rst_b) begin
         if (!rst_b) begin
            pre_cnt_r[g] <= 6'h0;
         end else if (clk_en) begin
            pre_cnt_r[g] <= pre_tick[g] ? 6'h0 : pre_cnt_r[g] + 6'h1;
         end
      end
   end

   // Rising edge of the synchronised external div 8 clock
   logic ext8_tick;
   assign ext8_tick = pin_s[4] & ~pin_prev_r[4];

   // Selected prescaled tick
   logic presc_tick;
   always_comb begin
      case (prescale_t'(timer_clock_select_r[`POS_PRESCALE_SELECT +: 2]))
         PRE_DIV12: presc_tick = pre_tick[0];
         PRE_DIV4:  presc_tick = pre_tick[1];
         PRE_DIV48: presc_tick = pre_tick[2];
         default:   presc_tick = ext8_tick;
      endcase
   end

   // -----------------------------------------------------------------------------
   // External interrupt levels and edges
   // -----------------------------------------------------------------------------
   logic [1:0] irq_act;
   logic [1:0] irq_edge;
   logic [1:0] evt_fall;
   assign irq_act[0] = ext_irq0_polarity ? pin_s[0] : ~pin_s[0];
   assign irq_act[1] = ext_irq1_polarity ? pin_s[1] : ~pin_s[1];
   assign irq_edge   = irq_act & ~irq_act_prev_r;
   // Event pins count high-to-low only; short pulses may be missed
   assign evt_fall   = pin_prev_r[3:2] & ~pin_s[3:2];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_act_prev_r <= 2'h0;
      end else if (clk_en) begin
         irq_act_prev_r <= irq_act;
      end
   end

   // -----------------------------------------------------------------------------
   // Timer 0 and split high byte
   // -----------------------------------------------------------------------------
   logic [1:0]  t0_mode;
   logic [1:0]  t1_mode;
   logic        t0_split;
   logic        t0_src;
   logic        t0_adv;
   logic        th_adv;
   count_step_t t0_step;
   assign t0_mode  = timer_mode_select_r[`POS_TIMER0_MODE_FIELD +: 2];
   assign t1_mode  = timer_mode_select_r[`POS_TIMER1_MODE_FIELD +: 2];
   assign t0_split = (t0_mode == MODE_SPLIT);
   // Counter function ignores the clock choice bit
   assign t0_src   = timer_mode_select_r[`BIT_TIMER0_COUNT_SELECT] ? evt_fall[0] :
                     (timer_clock_select_r[`BIT_TIMER0_CLOCK_CHOICE] ? 1'b1 : presc_tick);
   assign t0_adv   = timer_control_status_r[`BIT_TIMER0_RUN] & t0_src &
                     (~timer_mode_select_r[`BIT_TIMER0_GATE_ENABLE] | irq_act[0]);
   assign t0_step  = count_step(t0_mode, tl0_r, th0_r);
   // Split high byte: timer only, on timer 1 run bit
   assign th_adv   = t0_split & timer_control_status_r[`BIT_TIMER1_RUN] &
                     (timer_clock_select_r[`BIT_TIMER0_CLOCK_CHOICE] ? 1'b1 : presc_tick);

   // Software writes win over a count in the same cycle; run never reloads
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tl0_r <= `RESET_COUNT_BYTE;
         th0_r <= `RESET_COUNT_BYTE;
      end else if (clk_en) begin
         if (wr_hit(sfr_req, `ADDR_TIMER0_LOW_BYTE)) begin
            tl0_r <= sfr_req.wdata;
         end else if (t0_adv) begin
            tl0_r <= t0_step.lo;
         end
         if (wr_hit(sfr_req, `ADDR_TIMER0_HIGH_BYTE)) begin
            th0_r <= sfr_req.wdata;
         end else if (th_adv) begin
            th0_r <= th0_r + 8'h1;
         end else if (t0_adv && !t0_split) begin
            th0_r <= t0_step.hi;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Timer 1
   // -----------------------------------------------------------------------------
   logic        t1_src;
   logic        t1_run;
   logic        t1_adv;
   logic        t1_ovf;
   count_step_t t1_step;
   // Pin edges are not counted while timer 0 is split
   assign t1_src  = (timer_mode_select_r[`BIT_TIMER1_COUNT_SELECT] & ~t0_split) ? evt_fall[1] :
                    (timer_clock_select_r[`BIT_TIMER1_CLOCK_CHOICE] ? 1'b1 : presc_tick);
   // Split mode moves timer 1 run control onto its mode field
   assign t1_run  = t0_split ? (t1_mode != MODE_SPLIT) :
                    (timer_control_status_r[`BIT_TIMER1_RUN] & (t1_mode != MODE_SPLIT) &
                     (~timer_mode_select_r[`BIT_TIMER1_GATE_ENABLE] | irq_act[1]));
   assign t1_adv  = t1_run & t1_src;
   assign t1_step = count_step(t1_mode, tl1_r, th1_r);
   assign t1_ovf  = t1_adv & t1_step.ovf;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tl1_r <= `RESET_COUNT_BYTE;
         th1_r <= `RESET_COUNT_BYTE;
      end else if (clk_en) begin
         if (wr_hit(sfr_req, `ADDR_TIMER1_LOW_BYTE)) begin
            tl1_r <= sfr_req.wdata;
         end else if (t1_adv) begin
            tl1_r <= t1_step.lo;
         end
         if (wr_hit(sfr_req, `ADDR_TIMER1_HIGH_BYTE)) begin
            th1_r <= sfr_req.wdata;
         end else if (t1_adv) begin
            th1_r <= t1_step.hi;
         end
      end
   end

   // Overflow pulse for baud generators and converter start, also during split
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer1_overflow_pulse <= 1'b0;
      end else if (clk_en) begin
         timer1_overflow_pulse <= t1_ovf;
      end
   end

   // -----------------------------------------------------------------------------
   // Control/status register: hardware sets win over software clears
   // -----------------------------------------------------------------------------
   logic [7:0] timer_control_status_nxt;
   logic       timer_control_status_wr;
   logic       tf0_set;
   logic       tf1_set;
   logic [1:0] ie_set;
   assign timer_control_status_wr = wr_hit(sfr_req, `ADDR_TIMER_CONTROL_STATUS);
   assign tf0_set = t0_adv & t0_step.ovf;
   // In split mode only the high byte may raise timer 1's flag
   assign tf1_set = t0_split ? (th_adv & (&th0_r)) : t1_ovf;
   assign ie_set  = irq_edge;

   always_comb begin
      timer_control_status_nxt = timer_control_status_wr ? sfr_req.wdata : timer_control_status_r;
      // Vectoring clears timer flags
      if (vector_ack.timer0) begin
         timer_control_status_nxt[`BIT_TIMER0_OVERFLOW_FLAG] = 1'b0;
      end
      if (vector_ack.timer1) begin
         timer_control_status_nxt[`BIT_TIMER1_OVERFLOW_FLAG] = 1'b0;
      end
      if (tf0_set) begin
         timer_control_status_nxt[`BIT_TIMER0_OVERFLOW_FLAG] = 1'b1;
      end
      if (tf1_set) begin
         timer_control_status_nxt[`BIT_TIMER1_OVERFLOW_FLAG] = 1'b1;
      end
      // External flag 0: edge latches, level follows the input
      if (timer_control_status_nxt[`BIT_EXT_IRQ0_TRIGGER_TYPE]) begin
         if (vector_ack.ext_irq0) begin
            timer_control_status_nxt[`BIT_EXT_IRQ0_FLAG] = 1'b0;
         end
         if (ie_set[0]) begin
            timer_control_status_nxt[`BIT_EXT_IRQ0_FLAG] = 1'b1;
         end
      end else begin
         timer_control_status_nxt[`BIT_EXT_IRQ0_FLAG] = irq_act[0];
      end
      // External flag 1, same scheme
      if (timer_control_status_nxt[`BIT_EXT_IRQ1_TRIGGER_TYPE]) begin
         if (vector_ack.ext_irq1) begin
            timer_control_status_nxt[`BIT_EXT_IRQ1_FLAG] = 1'b0;
         end
         if (ie_set[1]) begin
            timer_control_status_nxt[`BIT_EXT_IRQ1_FLAG] = 1'b1;
         end
      end else begin
         timer_control_status_nxt[`BIT_EXT_IRQ1_FLAG] = irq_act[1];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_control_status_r <= `RESET_CONTROL_STATUS;
      end else if (clk_en) begin
         timer_control_status_r <= timer_control_status_nxt;
      end
   end

   // -----------------------------------------------------------------------------
   // Mode and clock select registers
   // -----------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_mode_select_r  <= `RESET_MODE_SELECT;
         timer_clock_select_r <= `RESET_CLOCK_SELECT;
      end else if (clk_en) begin
         if (wr_hit(sfr_req, `ADDR_TIMER_MODE_SELECT)) begin
            timer_mode_select_r <= sfr_req.wdata;
         end
         if (wr_hit(sfr_req, `ADDR_TIMER_CLOCK_SELECT)) begin
            timer_clock_select_r <= sfr_req.wdata;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Timer 2/3 clock ticks
   // -----------------------------------------------------------------------------
   logic t2_alt;
   logic t3_alt;
   logic t2_lo;
   logic t3_lo;
   assign t2_alt = timer2_alt_clock_choice ? ext8_tick : pre_tick[0];
   assign t3_alt = timer3_alt_clock_choice ? ext8_tick : pre_tick[0];
   assign t2_lo  = timer_clock_select_r[`BIT_TIMER2_LOW_CLOCK] ? 1'b1 : t2_alt;
   assign t3_lo  = timer_clock_select_r[`BIT_TIMER3_LOW_CLOCK] ? 1'b1 : t3_alt;

   // High-byte ticks are held low outside split mode, where the select is moot
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer2_low_tick  <= 1'b0;
         timer3_low_tick  <= 1'b0;
         timer2_high_tick <= 1'b0;
         timer3_high_tick <= 1'b0;
      end else if (clk_en) begin
         timer2_low_tick  <= t2_lo;
         timer3_low_tick  <= t3_lo;
         timer2_high_tick <= timer2_split &
                             (timer_clock_select_r[`BIT_TIMER2_HIGH_CLOCK] ? 1'b1 : t2_alt);
         timer3_high_tick <= timer3_split &
                             (timer_clock_select_r[`BIT_TIMER3_HIGH_CLOCK] ? 1'b1 : t3_alt);
      end
   end

   // -----------------------------------------------------------------------------
   // Read port: registered, unmapped addresses read zero
   // -----------------------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      case (sfr_req.addr)
         `ADDR_TIMER_CONTROL_STATUS: rd_mux = timer_control_status_r;
         `ADDR_TIMER_MODE_SELECT:    rd_mux = timer_mode_select_r;
         `ADDR_TIMER0_LOW_BYTE:      rd_mux = tl0_r;
         `ADDR_TIMER1_LOW_BYTE:      rd_mux = tl1_r;
         `ADDR_TIMER0_HIGH_BYTE:     rd_mux = th0_r;
         `ADDR_TIMER1_HIGH_BYTE:     rd_mux = th1_r;
         `ADDR_TIMER_CLOCK_SELECT:   rd_mux = timer_clock_select_r;
         default:                    rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else if (clk_en && sfr_req.rd) begin
         sfr_rdata <= rd_mux;
      end
   end

   // Interrupt requests are the flags themselves
   assign timer0_irq_req = timer_control_status_r[`BIT_TIMER0_OVERFLOW_FLAG];
   assign timer1_irq_req = timer_control_status_r[`BIT_TIMER1_OVERFLOW_FLAG];
   assign ext_irq0_req   = timer_control_status_r[`BIT_EXT_IRQ0_FLAG];
   assign ext_irq1_req   = timer_control_status_r[`BIT_EXT_IRQ1_FLAG];

endmodule
`default_nettype wire

// ### verification/timer01_asserts.sv
// Assertion checker for the timer 0/1 block
`timescale 1ns/1ns
`default_nettype none
module timer01_asserts
   import timer01_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        clk_en,
   input wire sfr_req_t    sfr_req,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        timer2_split,
   input wire logic        timer3_split,
   input wire vector_ack_t vector_ack,
   input wire logic        timer0_irq_req,
   input wire logic        timer1_irq_req,
   input wire logic        timer2_high_tick,
   input wire logic        timer3_high_tick
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Software write to control/status may legally clear any flag
   wire logic ctl_wr = clk_en && sfr_req.wr && sfr_req.addr == 8'h88;
   reset_zero_a: assert property (disable iff (1'b0) !rst_b |-> sfr_rdata == 8'h00
      && !timer0_irq_req && !timer1_irq_req) else $error("outputs not clear in reset");
   ctl_flags_a: assert property (clk_en && sfr_req.rd && sfr_req.addr == 8'h88
      |=> sfr_rdata[7] == $past(timer1_irq_req) && sfr_rdata[5] == $past(timer0_irq_req))
      else $error("control read disagrees with flags");
   flag0_hold_a: assert property (timer0_irq_req && !ctl_wr && !vector_ack.timer0
      |=> timer0_irq_req) else $error("timer 0 flag dropped");
   flag1_hold_a: assert property (timer1_irq_req && !ctl_wr && !vector_ack.timer1
      |=> timer1_irq_req) else $error("timer 1 flag dropped");
   // Gap cycle between write and read matches the core model's spacing
   mode_rw_a: assert property (clk_en && sfr_req.wr && sfr_req.addr == 8'h89
      ##1 !sfr_req.wr ##1 clk_en && sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'h89
      |=> sfr_rdata == $past(sfr_req.wdata, 3)) else $error("mode read back wrong");
   unmapped_rd_a: assert property (clk_en && sfr_req.rd && sfr_req.addr == 8'h8f
      |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   t2_high_a: assert property ((clk_en && !timer2_split) [*2] |-> !timer2_high_tick)
      else $error("timer 2 high tick outside split");
   t3_high_a: assert property ((clk_en && !timer3_split) [*2] |-> !timer3_high_tick)
      else $error("timer 3 high tick outside split");
   // Main scenarios reached
   cover property (timer1_irq_req && !timer0_irq_req);
   cover property (timer2_high_tick);
   cover property (ctl_wr);
endmodule
bind timer01_split_mode_and_control timer01_asserts i_asserts (.core_clk, .rst_b, .clk_en,
   .sfr_req, .sfr_rdata, .timer2_split, .timer3_split, .vector_ack, .timer0_irq_req,
   .timer1_irq_req, .timer2_high_tick, .timer3_high_tick);
`default_nettype wire

// ### verification/cpu_model.sv
// Core-side model making register accesses and vectoring acknowledges
`timescale 1ns/1ns
`default_nettype none
module cpu_model
   import timer01_pkg::*;
(
   input  wire logic [7:0]  sfr_rdata,
   input  wire logic        core_clk,
   output var sfr_req_t     sfr_req,
   output var vector_ack_t  vector_ack
);
   initial begin
      sfr_req = '0;
      vector_ack = '0;
   end
   // Each call ends idle, so two calls never drive the bus in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) sfr_req <= '{a, 1'b1, 1'b0, d};
      @(posedge core_clk) sfr_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk) sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge core_clk) sfr_req <= '0;
      @(posedge core_clk) d = sfr_rdata;
   endtask
   task automatic ack(input vector_ack_t v);
      @(posedge core_clk) vector_ack <= v;
      @(posedge core_clk) vector_ack <= '0;
   endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the timer 0/1 block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import timer01_pkg::*;
   logic        core_clk = 1'b0, rst_b = 1'b0, ext_irq0_input = 1'b1, ext_irq0_polarity = 1'b0;
   logic        ext_clk_div8 = 1'b0, timer0_irq_req, timer1_irq_req, ext_irq0_req;
   logic        timer1_overflow_pulse, timer2_high_tick, timer3_high_tick;
   logic [3:0]  t23 = 4'h0;
   logic        evt0 = 1'b1;
   logic [7:0]  sfr_rdata, d;
   int          n_errors = 0, n_tests = 0;
   sfr_req_t    sfr_req;
   vector_ack_t vector_ack;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) ext_clk_div8 <= ~ext_clk_div8;
   timer01_split_mode_and_control i_dut (.core_clk, .rst_b, .clk_en(1'b1), .sfr_req, .sfr_rdata,
      .vector_ack, .ext_irq0_input, .ext_irq1_input(ext_irq0_input), .ext_irq0_polarity,
      .ext_irq1_polarity(ext_irq0_polarity), .timer0_event_pin(evt0), .timer1_event_pin(1'b1),
      .ext_clk_div8, .timer2_alt_clock_choice(t23[1]), .timer3_alt_clock_choice(t23[0]),
      .timer2_split(t23[3]), .timer3_split(t23[2]), .timer0_irq_req, .timer1_irq_req,
      .ext_irq0_req, .ext_irq1_req(), .timer1_overflow_pulse, .timer2_low_tick(),
      .timer2_high_tick, .timer3_low_tick(), .timer3_high_tick);
   cpu_model i_cpu (.sfr_rdata, .core_clk, .sfr_req, .vector_ack);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      i_cpu.rd(a, d);
      chk(d, e);
   endtask
   task automatic results;
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Watchdog: the sequence needs about a thousand ns
   initial begin
      #40000;
      n_errors++;
      results();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge core_clk);
      for (int a = 8'h88; a <= 8'h8f; a++) rc(8'(a), 8'h00);
      i_cpu.wr(8'h89, 8'h03);
      rc(8'h89, 8'h03);
      // Split high byte on system clock, run by the timer 1 run bit
      t23 <= 4'hf;
      i_cpu.wr(8'h8e, 8'h24);
      i_cpu.wr(8'h8c, 8'hf0);
      i_cpu.wr(8'h88, 8'h40);
      repeat (40) if (timer1_irq_req !== 1'b1) @(posedge core_clk);
      chk({5'h00, timer1_irq_req, timer0_irq_req, timer2_high_tick}, 8'h05);
      rc(8'h8a, 8'h00);
      rc(8'h88, 8'hc0);
      // Timer 1 keeps running on its mode alone, cleared flag stays clear
      i_cpu.wr(8'h88, 8'h00);
      i_cpu.wr(8'h8b, 8'hff);
      i_cpu.wr(8'h8d, 8'hff);
      i_cpu.wr(8'h8e, 8'h2c);
      i_cpu.wr(8'h89, 8'h23);
      repeat (40) if (timer1_overflow_pulse !== 1'b1) @(posedge core_clk);
      chk({6'h00, timer1_overflow_pulse, timer1_irq_req}, 8'h02);
      i_cpu.wr(8'h89, 8'h33);
      repeat (4) @(posedge core_clk);
      repeat (10) @(posedge core_clk) chk({7'h00, timer1_overflow_pulse}, 8'h00);
      // 16-bit rollover from the loaded value on the divide-by-48 clock
      i_cpu.wr(8'h89, 8'h01);
      i_cpu.wr(8'h8e, 8'h02);
      i_cpu.wr(8'h8a, 8'hff);
      i_cpu.wr(8'h8c, 8'hff);
      i_cpu.wr(8'h88, 8'h90);
      repeat (120) if (timer0_irq_req !== 1'b1) @(posedge core_clk);
      i_cpu.wr(8'h88, 8'ha0);
      rc(8'h8a, 8'h00);
      rc(8'h8c, 8'h00);
      // Counter function: slow falling edges, each level held four cycles
      i_cpu.wr(8'h89, 8'h05);
      i_cpu.wr(8'h88, 8'h10);
      repeat (3) begin
         evt0 <= 1'b0;
         repeat (4) @(posedge core_clk);
         evt0 <= 1'b1;
         repeat (4) @(posedge core_clk);
      end
      rc(8'h8a, 8'h03);
      // Level then edge triggering of external input 0, active low first
      ext_irq0_input <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk({7'h00, ext_irq0_req}, 8'h01);
      ext_irq0_polarity <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk({7'h00, ext_irq0_req}, 8'h00);
      i_cpu.wr(8'h88, 8'ha1);
      ext_irq0_input <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk({7'h00, ext_irq0_req}, 8'h01);
      i_cpu.ack(4'b1110);
      // Input 1 shares the pin: level mode, active high, so its flag reads set
      rc(8'h88, 8'h09);
      results();
   end
endmodule
`default_nettype wire
